// *** csw_defs.svh ***
// Operation
// - input alarm bits 0,1: over, under range
// - input alarm bit 2: junction or thermometer fault
// - input alarm bit 10: transformer over range
// - instrument alarm bit 0: memory fault
// - instrument alarm bit 2: conversion fault
// - bit 4 adjustment error, bits 5,6 area
// - bit 8 system fault, bit 9 init failure
// - bit 12: memory never initialised
// - events bits 0-4, contacts bits 8-10
// - control bit 0: auto 0, manual 1
// - control bit 1: run 0, standby 1
// - control bit 3 while autotune runs
// - bits 6,7,8: any, up, down ramp
// - bits 13,14: heating, cooling gain set
// - gain bits valid only when heat/cool is 1
// - outputs word, mirrored at 14337
// - inputs word, mirrored at 14338
// - packed user bits plus single words
`ifndef CSW_DEFS_SVH
`define CSW_DEFS_SVH

// register indices; the byte address is four times the index
`define CSW_IDX_IN_ALARM 16'h23F1
`define CSW_IDX_INST_ALARM 16'h23F2
`define CSW_IDX_EVT_CONTACT 16'h23F3
`define CSW_IDX_LOOP_MODE 16'h23F4
`define CSW_IDX_OUT_TERM 16'h23F5
`define CSW_IDX_IN_TERM 16'h23F6
`define CSW_IDX_USER_PACKED 16'h23F7
`define CSW_IDX_USER_ONE 16'h23F8
`define CSW_IDX_USER_TWO 16'h23F9
`define CSW_IDX_USER_THREE 16'h23FA
`define CSW_IDX_USER_FOUR 16'h23FB
`define CSW_IDX_OUT_TERM_ALIAS 16'h3801
`define CSW_IDX_IN_TERM_ALIAS 16'h3802
`define CSW_IDX_HEATCOOL_CFG 16'h23F0

// field positions
`define CSW_BIT_RAMP_ANY 6
`define CSW_BIT_HEAT_GAIN 13
`define CSW_BIT_COOL_GAIN 14

// values
`define CSW_HEATCOOL_INDIVIDUAL 16'h0001
`define CSW_HEATCOOL_RESET 16'h0000
`define CSW_USER_RESET 4'h0

`endif

// *** csw_pkg.sv ***
package csw_pkg;

	// live state reported by the measurement and control functions
	typedef struct packed {
		logic pv_over; // process_value over range
		logic pv_under; // process_value under range
		logic cjc_fault; // junction compensation or resistance_thermometer fault
		logic ct_over; // current_transformer_input over range
		logic nvm_fault;
		logic adc_fault;
		logic adj_err;
		logic adj_area1;
		logic adj_area2;
		logic sys_fault;
		logic init_fail;
		logic nvm_blank;
		logic [4:0] events;
		logic [2:0] contacts;
		logic manual;
		logic standby;
		logic autotune;
		logic ramp_up; // setpoint rising
		logic ramp_down; // setpoint falling
		logic heat_gain; // heating loop_gain_set in use
		logic cool_gain; // cooling loop_gain_set in use
		logic [1:0] ctrl_out;
		logic [2:0] event_out;
		logic [1:0] contact_input; // contact_input_one, contact_input_two
	} csw_status_t;

endpackage : csw_pkg

// *** csw_bank.sv ***
`timescale 1ns/1ns
`include "csw_defs.svh"

module csw_bank
	import csw_pkg::*;
#(
	parameter int USER_BITS = 4
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire csw_status_t status,
	output logic [USER_BITS-1:0] user_flags
);

	// elaboration check: only four single-bit words are mapped
	if (USER_BITS < 1 || USER_BITS > 4) begin : g_bad_user
		$error("csw_bank: USER_BITS must be 1 to 4");
	end

	logic [31:0] hrdata_reg;
	logic [31:0] hrdata_next;
	logic hreadyout_reg;
	logic hresp_reg;
	logic [USER_BITS-1:0] user_reg;
	logic [USER_BITS-1:0] user_next;
	logic [15:0] heatcool_reg;
	logic [15:0] heatcool_next;
	logic wr_pend_reg;
	logic [15:0] wr_idx_reg;

	// address phase decode
	wire logic addr_ok = hsel && htrans[1] && hready;
	wire logic in_range = (haddr[31:18] == 14'h0000);
	wire logic [15:0] idx = haddr[17:2];
	wire logic rd_take = addr_ok && !hwrite && in_range;
	wire logic wr_take = addr_ok && hwrite && in_range;

	// data phase write decode against the registered index
	wire logic wr_packed = wr_pend_reg && (wr_idx_reg == `CSW_IDX_USER_PACKED);
	wire logic wr_cfg = wr_pend_reg && (wr_idx_reg == `CSW_IDX_HEATCOOL_CFG);
	wire logic [15:0] single_off = wr_idx_reg - `CSW_IDX_USER_ONE;
	wire logic wr_single = wr_pend_reg && (wr_idx_reg >= `CSW_IDX_USER_ONE)
		&& (single_off < 16'(USER_BITS));
	wire logic [1:0] single_sel = single_off[1:0];

	// status words, undefined positions tied to zero
	wire logic [15:0] in_alarm_w = {5'h00, status.ct_over, 7'h00,
		status.cjc_fault,
		status.pv_under, status.pv_over};
	wire logic [15:0] inst_alarm_w = {3'h0, status.nvm_blank, 2'h0,
		status.init_fail, status.sys_fault, 1'b0,
		status.adj_area2, status.adj_area1, status.adj_err, 1'b0,
		status.adc_fault, 1'b0,
		status.nvm_fault};
	wire logic [15:0] evt_w = {5'h00, status.contacts, 3'h0, status.events};
	wire logic gains_valid = (heatcool_reg == `CSW_HEATCOOL_INDIVIDUAL);
	wire logic heat_v = status.heat_gain && gains_valid;
	wire logic cool_v = status.cool_gain && gains_valid;
	wire logic ramp_any = status.ramp_up || status.ramp_down;
	wire logic [15:0] mode_w = {1'b0, cool_v, heat_v, 4'h0,
		status.ramp_down, status.ramp_up, ramp_any,
		2'h0, status.autotune,
		1'b0, status.standby,
		status.manual};
	wire logic [15:0] dout_w = {11'h000, status.event_out, status.ctrl_out};
	wire logic [15:0] din_w = {14'h0000, status.contact_input};
	wire logic [3:0] user_pad = 4'(user_next);

	// user flag update; both views share one store
	always_comb begin
		user_next = user_reg;
		if (wr_packed) begin
			user_next = hwdata[USER_BITS-1:0];
		end else if (wr_single) begin
			user_next[single_sel] = hwdata[0];
		end
	end

	assign heatcool_next = wr_cfg ? hwdata[15:0] : heatcool_reg;

	// read selection; user words read the post-write value
	always_comb begin
		hrdata_next = 32'h00000000;
		if (rd_take) begin
			unique case (idx)
				`CSW_IDX_IN_ALARM: hrdata_next = {16'h0000, in_alarm_w};
				`CSW_IDX_INST_ALARM: hrdata_next = {16'h0000, inst_alarm_w};
				`CSW_IDX_EVT_CONTACT: hrdata_next = {16'h0000, evt_w};
				`CSW_IDX_LOOP_MODE: hrdata_next = {16'h0000, mode_w};
				`CSW_IDX_OUT_TERM, `CSW_IDX_OUT_TERM_ALIAS:
					hrdata_next = {16'h0000, dout_w};
				`CSW_IDX_IN_TERM, `CSW_IDX_IN_TERM_ALIAS:
					hrdata_next = {16'h0000, din_w};
				`CSW_IDX_USER_PACKED: hrdata_next = {28'h0000000, user_pad};
				`CSW_IDX_USER_ONE: hrdata_next = {31'h00000000, user_pad[0]};
				`CSW_IDX_USER_TWO: hrdata_next = {31'h00000000, user_pad[1]};
				`CSW_IDX_USER_THREE: hrdata_next = {31'h00000000, user_pad[2]};
				`CSW_IDX_USER_FOUR: hrdata_next = {31'h00000000, user_pad[3]};
				`CSW_IDX_HEATCOOL_CFG: hrdata_next = {16'h0000, heatcool_reg};
				default: hrdata_next = 32'h00000000;
			endcase
		end
	end

	// bus pipeline state; writes to status words are dropped
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wr_pend_reg <= 1'b0;
			wr_idx_reg <= 16'h0000;
		end else begin
			wr_pend_reg <= wr_take;
			wr_idx_reg <= wr_take ? idx : 16'h0000;
		end
	end

	// storage and registered outputs
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			user_reg <= USER_BITS'(`CSW_USER_RESET);
			heatcool_reg <= `CSW_HEATCOOL_RESET;
			hrdata_reg <= 32'h00000000;
			hreadyout_reg <= 1'b1;
			hresp_reg <= 1'b0;
		end else begin
			user_reg <= user_next;
			heatcool_reg <= heatcool_next;
			hrdata_reg <= hrdata_next;
			hreadyout_reg <= 1'b1;
			hresp_reg <= 1'b0;
		end
	end

	assign hrdata = hrdata_reg;
	assign hreadyout = hreadyout_reg;
	assign hresp = hresp_reg;
	assign user_flags = user_reg;

	// checks beside the read path
	in_alarm_rd_a: assert property (@(posedge clk) disable iff (!arst_n)
		(rd_take && idx == `CSW_IDX_IN_ALARM) |=> (hrdata[10] == $past(status.ct_over))
		&& (hrdata[2:0] == {$past(status.cjc_fault), $past(status.pv_under),
		$past(status.pv_over)}) && (hrdata[9:3] == 7'h00))
		else $error("input alarm word wrong");

	inst_alarm_rd_a: assert property (@(posedge clk) disable iff (!arst_n)
		(rd_take && idx == `CSW_IDX_INST_ALARM) |=> (hrdata[0] == $past(status.nvm_fault))
		&& (hrdata[2] == $past(status.adc_fault)) && !hrdata[1] && !hrdata[3])
		else $error("instrument alarm low bits wrong");

	inst_alarm_hi_a: assert property (@(posedge clk) disable iff (!arst_n)
		(rd_take && idx == `CSW_IDX_INST_ALARM) |=> (hrdata[6:4] == {$past(status.adj_area2),
		$past(status.adj_area1), $past(status.adj_err)}) && (hrdata[9:8] ==
		{$past(status.init_fail), $past(status.sys_fault)}) && (hrdata[12] ==
		$past(status.nvm_blank)) && (hrdata[31:13] == 19'h00000))
		else $error("instrument alarm high bits wrong");

	evt_rd_a: assert property (@(posedge clk) disable iff (!arst_n)
		(rd_take && idx == `CSW_IDX_EVT_CONTACT) |=> (hrdata[4:0] == $past(status.events))
		&& (hrdata[10:8] == $past(status.contacts)) && (hrdata[7:5] == 3'h0))
		else $error("event and contact word wrong");

	mode_rd_a: assert property (@(posedge clk) disable iff (!arst_n)
		(rd_take && idx == `CSW_IDX_LOOP_MODE) |=> (hrdata[1:0] == {$past(status.standby),
		$past(status.manual)}) && (hrdata[3] == $past(status.autotune))
		&& (hrdata[`CSW_BIT_RAMP_ANY] == ($past(status.ramp_up) || $past(status.ramp_down)))
		&& (hrdata[8:7] == {$past(status.ramp_down), $past(status.ramp_up)}))
		else $error("control status word wrong");

	gain_gate_a: assert property (@(posedge clk) disable iff (!arst_n)
		(rd_take && idx == `CSW_IDX_LOOP_MODE) |=> (hrdata[`CSW_BIT_HEAT_GAIN] ==
		($past(status.heat_gain) && $past(heatcool_reg) == `CSW_HEATCOOL_INDIVIDUAL))
		&& (hrdata[`CSW_BIT_COOL_GAIN] == ($past(status.cool_gain)
		&& $past(heatcool_reg) == `CSW_HEATCOOL_INDIVIDUAL)))
		else $error("gain set bits not gated");

	term_alias_a: assert property (@(posedge clk) disable iff (!arst_n)
		(rd_take && (idx == `CSW_IDX_OUT_TERM_ALIAS || idx == `CSW_IDX_IN_TERM_ALIAS))
		|=> (hrdata == (($past(idx) == `CSW_IDX_OUT_TERM_ALIAS) ? {27'h0000000,
		$past(status.event_out), $past(status.ctrl_out)} : {30'h00000000,
		$past(status.contact_input)})))
		else $error("terminal mirror word wrong");

	status_ro_a: assert property (@(posedge clk) disable iff (!arst_n)
		(wr_pend_reg && !wr_packed && !wr_single && !wr_cfg) |-> (user_next == user_reg)
		&& (heatcool_next == heatcool_reg))
		else $error("status write changed storage");

	user_views_a: assert property (@(posedge clk) disable iff (!arst_n)
		wr_packed |=> (user_reg == $past(hwdata[USER_BITS-1:0])))
		else $error("packed user write lost");

	user_single_a: assert property (@(posedge clk) disable iff (!arst_n)
		(rd_take && idx == `CSW_IDX_USER_ONE) |=> (hrdata == {31'h00000000,
		$past(user_next[0])}) && (hrdata[0] == user_reg[0]))
		else $error("single user bit view disagrees");

	// checks on the bus handshake itself

	// the slave never stretches a transfer and always answers okay
	bus_ready_a: assert property (@(posedge clk) disable iff (!arst_n)
		1'b1 |-> (hreadyout && !hresp))
		else $error("bus ready or response wrong");

	// read data drops back to zero when no read was taken
	rd_idle_a: assert property (@(posedge clk) disable iff (!arst_n)
		!rd_take |=> (hrdata == 32'h00000000))
		else $error("read data left standing");

	// no word is wider than sixteen bits, the upper half reads zero
	rd_upper_a: assert property (@(posedge clk) disable iff (!arst_n)
		rd_take |=> (hrdata[31:16] == 16'h0000))
		else $error("upper half of read data not zero");

	// an index outside the map reads zero
	unmapped_rd_a: assert property (@(posedge clk) disable iff (!arst_n)
		(rd_take && !(idx inside {`CSW_IDX_IN_ALARM, `CSW_IDX_INST_ALARM,
		`CSW_IDX_EVT_CONTACT, `CSW_IDX_LOOP_MODE, `CSW_IDX_OUT_TERM, `CSW_IDX_IN_TERM,
		`CSW_IDX_USER_PACKED, `CSW_IDX_USER_ONE, `CSW_IDX_USER_TWO, `CSW_IDX_USER_THREE,
		`CSW_IDX_USER_FOUR, `CSW_IDX_OUT_TERM_ALIAS, `CSW_IDX_IN_TERM_ALIAS,
		`CSW_IDX_HEATCOOL_CFG}))
		|=> (hrdata == 32'h00000000))
		else $error("unmapped read not zero");

	// addresses above the map are neither read nor written
	out_range_a: assert property (@(posedge clk) disable iff (!arst_n)
		(addr_ok && !in_range) |=> (!wr_pend_reg && (hrdata == 32'h00000000)))
		else $error("out of range access took effect");

	// a write aimed at a status word never reaches storage
	status_wr_a: assert property (@(posedge clk) disable iff (!arst_n)
		(wr_take && (idx inside {`CSW_IDX_IN_ALARM, `CSW_IDX_INST_ALARM,
		`CSW_IDX_EVT_CONTACT, `CSW_IDX_LOOP_MODE, `CSW_IDX_OUT_TERM, `CSW_IDX_IN_TERM,
		`CSW_IDX_OUT_TERM_ALIAS, `CSW_IDX_IN_TERM_ALIAS}))
		|=> (!wr_packed && !wr_single && !wr_cfg))
		else $error("status word write decoded as store");

	// checks on the undefined positions of the status words

	// input alarm word, bits above the transformer flag
	in_alarm_undef_a: assert property (@(posedge clk) disable iff (!arst_n)
		(rd_take && idx == `CSW_IDX_IN_ALARM) |=> (hrdata[15:11] == 5'h00))
		else $error("input alarm undefined bits set");

	// instrument alarm word, gaps between the fault flags
	inst_undef_a: assert property (@(posedge clk) disable iff (!arst_n)
		(rd_take && idx == `CSW_IDX_INST_ALARM) |=> (!hrdata[7]
		&& (hrdata[11:10] == 2'h0)))
		else $error("instrument alarm undefined bits set");

	// event and contact word, bits above the contacts
	evt_undef_a: assert property (@(posedge clk) disable iff (!arst_n)
		(rd_take && idx == `CSW_IDX_EVT_CONTACT) |=> (hrdata[15:11] == 5'h00))
		else $error("event word undefined bits set");

	// control status word, every undefined position
	mode_undef_a: assert property (@(posedge clk) disable iff (!arst_n)
		(rd_take && idx == `CSW_IDX_LOOP_MODE) |=> (!hrdata[2] && (hrdata[5:4] == 2'h0)
		&& (hrdata[12:9] == 4'h0) && !hrdata[15]))
		else $error("control status undefined bits set");

	// gain set bits stay low unless individual gain sets are chosen
	heat_cool_off_a: assert property (@(posedge clk) disable iff (!arst_n)
		(rd_take && idx == `CSW_IDX_LOOP_MODE && !gains_valid)
		|=> (hrdata[`CSW_BIT_COOL_GAIN:`CSW_BIT_HEAT_GAIN] == 2'h0))
		else $error("gain set bits shown while not valid");

	// checks on the terminal words at their own index

	// output terminal word, control then event outputs
	dout_rd_a: assert property (@(posedge clk) disable iff (!arst_n)
		(rd_take && idx == `CSW_IDX_OUT_TERM) |=> (hrdata == {27'h0000000,
		$past(status.event_out), $past(status.ctrl_out)}))
		else $error("output terminal word wrong");

	// input terminal word, two contact inputs
	din_rd_a: assert property (@(posedge clk) disable iff (!arst_n)
		(rd_take && idx == `CSW_IDX_IN_TERM) |=> (hrdata == {30'h00000000,
		$past(status.contact_input)}))
		else $error("input terminal word wrong");

	// checks on the two views of the user bits

	// packed word shows all user bits at once
	user_packed_rd_a: assert property (@(posedge clk) disable iff (!arst_n)
		(rd_take && idx == `CSW_IDX_USER_PACKED) |=> (hrdata == {28'h0000000,
		$past(user_pad)}))
		else $error("packed user word wrong");

	// second user bit as its own word
	user_two_rd_a: assert property (@(posedge clk) disable iff (!arst_n)
		(rd_take && idx == `CSW_IDX_USER_TWO) |=> (hrdata == {31'h00000000,
		$past(user_pad[1])}))
		else $error("second user bit word wrong");

	// third user bit as its own word
	user_three_rd_a: assert property (@(posedge clk) disable iff (!arst_n)
		(rd_take && idx == `CSW_IDX_USER_THREE) |=> (hrdata == {31'h00000000,
		$past(user_pad[2])}))
		else $error("third user bit word wrong");

	// fourth user bit as its own word
	user_four_rd_a: assert property (@(posedge clk) disable iff (!arst_n)
		(rd_take && idx == `CSW_IDX_USER_FOUR) |=> (hrdata == {31'h00000000,
		$past(user_pad[3])}))
		else $error("fourth user bit word wrong");

	// a single bit write takes bit zero of the data
	single_wr_a: assert property (@(posedge clk) disable iff (!arst_n)
		wr_single |-> (user_next[single_sel] == hwdata[0]))
		else $error("single user bit write lost");

	// a single bit write leaves the other user bits alone
	single_keep_a: assert property (@(posedge clk) disable iff (!arst_n)
		wr_single |=> (((user_reg ^ $past(user_reg))
		& ~(USER_BITS'(1) << $past(single_sel))) == '0))
		else $error("single user write disturbed other bits");

	// without a user write the store holds
	user_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
		(!wr_packed && !wr_single) |-> (user_next == user_reg))
		else $error("user bits changed without a write");

	// the user bit pins follow the store
	flags_out_a: assert property (@(posedge clk) disable iff (!arst_n)
		1'b1 |-> (user_flags == user_reg))
		else $error("user flag outputs differ from store");

	// checks on the heat and cool setting

	// a setting write lands whole
	cfg_wr_a: assert property (@(posedge clk) disable iff (!arst_n)
		wr_cfg |=> (heatcool_reg == $past(hwdata[15:0])))
		else $error("heat cool setting write lost");

	// without a setting write the value holds
	cfg_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
		!wr_cfg |-> (heatcool_next == heatcool_reg))
		else $error("heat cool setting changed without a write");

	// the setting reads back as stored
	cfg_rd_a: assert property (@(posedge clk) disable iff (!arst_n)
		(rd_take && idx == `CSW_IDX_HEATCOOL_CFG) |=> (hrdata == {16'h0000,
		$past(heatcool_reg)}))
		else $error("heat cool setting read wrong");

	// a taken write carries its index into the data phase
	wr_pipe_a: assert property (@(posedge clk) disable iff (!arst_n)
		wr_take |=> (wr_pend_reg && (wr_idx_reg == $past(idx))))
		else $error("write index not carried to data phase");

endmodule : csw_bank

// *** csw_host.sv ***
`timescale 1ns/1ns
// bus master standing in for the host computer
module csw_host (
	input wire logic clk,
	output logic hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata
);
	// idle bus at time zero
	initial begin
		{hsel, haddr, htrans, hwrite, hwdata} = '0;
		hsize = 3'h2;
	end

	// one single word transfer; to is set when hready never came
	task automatic xfer(input logic w, input logic [15:0] idx, input logic [31:0] wd,
		output logic [31:0] rd, output bit to);
		int n;
		n = 0;
		hsel <= 1'b1;
		haddr <= {14'h0000, idx, 2'h0};
		htrans <= 2'h2;
		hwrite <= w;
		do begin
			@(posedge clk);
			n++;
		end while (hready !== 1'b1 && n < 16);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do begin
			@(posedge clk);
			n++;
		end while (hready !== 1'b1 && n < 32);
		rd = hrdata;
		hwdata <= ~wd; // released data lines show no stale value
		to = n >= 32;
	endtask : xfer
endmodule : csw_host

// *** tb.sv ***
`timescale 1ns/1ns
`include "csw_defs.svh"
module tb
	import csw_pkg::*;
;
	logic clk = 1'b0;
	logic arst_n;
	logic hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, d, wd;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [3:0] user_flags, p;
	csw_status_t status;
	int n_mismatch, n_tests, g, k, i, j;
	integer seed = 32'h25D9;
	logic [15:0] words [9] = '{`CSW_IDX_IN_ALARM, `CSW_IDX_INST_ALARM, `CSW_IDX_EVT_CONTACT,
		`CSW_IDX_LOOP_MODE, `CSW_IDX_OUT_TERM, `CSW_IDX_IN_TERM, `CSW_IDX_OUT_TERM_ALIAS,
		`CSW_IDX_IN_TERM_ALIAS, 16'h1000};

	always #50 clk = ~clk;

	csw_host host (.clk(clk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata));

	csw_bank DUT (.clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .status(status), .user_flags(user_flags));

	// expected word at an index for a given state
	function automatic logic [31:0] exp_word(logic [15:0] idx, csw_status_t s, logic gs);
		logic [15:0] w;
		w = '0;
		case (idx)
			`CSW_IDX_IN_ALARM: w[10] = s.ct_over;
			`CSW_IDX_INST_ALARM: w[12] = s.nvm_blank;
			`CSW_IDX_EVT_CONTACT: w[10:8] = s.contacts;
			`CSW_IDX_LOOP_MODE: w[14:13] = {s.cool_gain, s.heat_gain} & {2{gs}};
			`CSW_IDX_OUT_TERM, `CSW_IDX_OUT_TERM_ALIAS: w[4:0] = {s.event_out, s.ctrl_out};
			`CSW_IDX_IN_TERM, `CSW_IDX_IN_TERM_ALIAS: w[1:0] = s.contact_input;
			default: w = '0;
		endcase
		if (idx == `CSW_IDX_IN_ALARM)
			w[2:0] = {s.cjc_fault, s.pv_under, s.pv_over};
		if (idx == `CSW_IDX_INST_ALARM)
			w[9:0] = {s.init_fail, s.sys_fault, 1'b0, s.adj_area2, s.adj_area1, s.adj_err,
				1'b0, s.adc_fault, 1'b0, s.nvm_fault};
		if (idx == `CSW_IDX_EVT_CONTACT)
			w[4:0] = s.events;
		if (idx == `CSW_IDX_LOOP_MODE)
			w[8:0] = {s.ramp_down, s.ramp_up, s.ramp_up | s.ramp_down, 2'h0, s.autotune,
				1'b0, s.standby, s.manual};
		return {16'h0000, w};
	endfunction : exp_word

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : complete_run

	// one bus transfer; a hang counts and ends the run
	task automatic bus(input logic w, input logic [15:0] idx, input logic [31:0] v);
		bit to;
		host.xfer(w, idx, v, d, to);
		if (to) begin
			n_mismatch++;
			complete_run();
		end
	endtask : bus

	initial begin
		arst_n = 1'b0;
		status = '0;
		repeat (12) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		// status words under each heat/cool setting, with refused writes first
		for (g = 0; g < 3; g++) begin
			bus(1'b1, `CSW_IDX_HEATCOOL_CFG, g);
			for (k = 0; k < 8; k++) begin
				status <= (k == 0) ? '1 : csw_status_t'({$random(seed), $random(seed)} >> 30);
				for (i = 0; i < 9; i++) begin
					bus(1'b1, words[i], 32'hFFFFFFFF);
					bus(1'b0, words[i], 32'h0);
					check(d, exp_word(words[i], status, g == 1));
				end
			end
		end
		$display("status words done");
		// both user views, packed and single words
		for (k = 0; k < 8; k++) begin
			wd = $random(seed);
			p = (k == 0) ? 4'hF : wd[3:0];
			bus(1'b1, `CSW_IDX_USER_PACKED, (k == 0) ? 32'hFFFFFFFF : wd);
			for (j = 0; j < 4; j++) begin
				bus(1'b0, `CSW_IDX_USER_ONE + j[15:0], 32'h0);
				check(d, {31'h0, p[j]});
			end
			wd = $random(seed);
			j = k % 4;
			p[j] = wd[0];
			bus(1'b1, `CSW_IDX_USER_ONE + j[15:0], wd);
			bus(1'b0, `CSW_IDX_USER_PACKED, 32'h0);
			check(d, {28'h0, p});
			check({28'h0, user_flags}, {28'h0, p});
		end
		$display("user words done");
		// second reset in mid-run clears the user bits
		arst_n <= 1'b0;
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		bus(1'b0, `CSW_IDX_USER_PACKED, 32'h0);
		check(d, 32'h0);
		check({31'h0, hresp}, 32'h0);
		$display("reset test done");
		complete_run();
	end
endmodule : tb
